// [cpl_cfg.svh]
// constants for the memory-side coupler: bit positions, codes, sizes
`ifndef CPL_CFG_SVH
`define CPL_CFG_SVH

// first output channel: connect code field and coupler select
`define CPL_CONN_LSB      13
`define CPL_CONN_MSB      15
`define CPL_CONN_CODE     3'h3
`define CPL_SEL_BIT       8

// second output channel: set/clear control bits
`define CPL_ICLR_BIT      11
`define CPL_PCLR_BIT      12

// fifth input channel layout
`define CPL_ST_ERR_BIT    0
`define CPL_ST_BANK_LSB   1
`define CPL_ST_BANK_MSB   3

// buffer memory geometry
`define CPL_WORD_W        16
`define CPL_ADDR_W        16
`define CPL_BANK_LSB      13
`define CPL_BANK_MSB      15
`define CPL_BANK_BACK     3'h4

// operation function codes from the far end
`define CPL_FC_END        2'h0
`define CPL_FC_READ       2'h1
`define CPL_FC_WRITE      2'h2

// read-data buffer
`define CPL_FIFO_DEPTH    32
`define CPL_FIFO_AW       5

`endif

// [cpl_pkg.sv]
// types shared by the memory-side coupler files
`include "cpl_cfg.svh"

package cpl_pkg;

  // one word fetched from buffer memory with its two odd-parity bits
  typedef struct packed {
    logic [`CPL_WORD_W-1:0] data;
    logic [1:0]             par;
  } cpl_mem_word_t;

  // operation request from the far end
  typedef struct packed {
    logic [1:0]             code;
    logic [`CPL_ADDR_W-1:0] addr;
  } cpl_func_t;

  // gray codes along idle -> read -> wait -> read
  typedef enum logic [1:0] {
    CPL_ST_IDLE  = 2'b00,
    CPL_ST_READ  = 2'b01,
    CPL_ST_WAIT  = 2'b11,
    CPL_ST_WRITE = 2'b10
  } cpl_state_t;

endpackage

// [cpl_fifo.sv]
// read-data buffer with registered head word, valid/ready on both sides
module cpl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_clr,
  // fill side
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_wr_ready,
  // drain side
  output logic                  o_rd_valid,
  output logic      [WIDTH-1:0] o_rd_data,
  input  wire logic             i_rd_ready
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             wr_fire;
  logic             load;

  assign o_wr_ready = (count != AW'(0) + (AW+1)'(DEPTH));
  assign wr_fire    = i_wr_valid && o_wr_ready;
  // head register refills whenever it is empty or being taken
  assign load       = (count != '0) && (!o_rd_valid || i_rd_ready);

  always_ff @(posedge i_clk) begin
    if (wr_fire) begin
      mem[wr_ptr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (i_clr) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (wr_fire) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (load) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      count <= (AW+1)'(count + {AW'(0), wr_fire} - {AW'(0), load});
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
    end else if (i_clr) begin
      o_rd_valid <= 1'b0;
    end else if (load) begin
      o_rd_valid <= 1'b1;
      o_rd_data  <= mem[rd_ptr];
    end else if (i_rd_ready) begin
      o_rd_valid <= 1'b0;
    end
  end

endmodule

// [cpl_coupler.sv]
// memory-side coupler: block read with parity check, channel control bits
//
// Summary of operation
// - check parity of every fetched 16-bit word
// - report memory parity error to far end
// - present three-bit bank count to processor
// - parity error does not stop block read
// - after a parity error, refuse new operations until end or clear
// - hold bank bits until end of operation
// - connect code bits attach the group
// - select bit needs valid connect code too
// - program clear resets operation, error, bank
// - status bit zero shows coupler parity error
// - status bits one-three show selected bank counter
// - connected exactly while connect code held
// - interrupt clear pulse resets interrupt-from-far-end bit
`include "cpl_cfg.svh"

module cpl_coupler
  import cpl_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst_b,
  // processor normal channels (pins)
  input  wire logic [15:0]            i_first_output_channel,
  input  wire logic [15:0]            i_second_output_channel,
  output logic      [15:0]            o_fifth_input_channel,
  // bank counter of the selected peripheral interface
  input  wire logic [2:0]             i_periph_bank_cnt,
  // buffer memory port
  output logic                        o_mem_rd_req,
  output logic                        o_mem_wr_en,
  output logic      [`CPL_ADDR_W-1:0] o_mem_addr,
  output logic      [`CPL_WORD_W-1:0] o_mem_wr_data,
  input  wire logic                   i_mem_rd_valid,
  input  wire cpl_mem_word_t          i_mem_rd,
  // far end: operation requests
  input  wire logic                   i_b_func_stb,
  input  wire cpl_func_t              i_b_func,
  output logic                        o_b_func_refused,
  // far end: write data
  input  wire logic                   i_b_wr_valid,
  input  wire logic [`CPL_WORD_W-1:0] i_b_wr_data,
  // far end: read data and error
  output logic                        o_b_rd_valid,
  output logic      [`CPL_WORD_W-1:0] o_b_rd_data,
  input  wire logic                   i_b_rd_ready,
  output logic                        o_b_par_err,
  // far end interrupt
  input  wire logic                   i_b_int_stb,
  output logic                        o_int_from_b
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // odd parity per byte: each byte plus its bit has an odd count of ones
  function automatic logic word_ok(input cpl_mem_word_t w);
    word_ok = (^{w.data[7:0], w.par[0]}) && (^{w.data[15:8], w.par[1]});
  endfunction

  // counter reads back as bank once complemented and stepped back four
  function automatic logic [2:0] bank_cnt(input logic [2:0] bank);
    bank_cnt = ~(3'(bank + `CPL_BANK_BACK));
  endfunction

  // status field carries the weight-4 bit lowest
  function automatic logic [2:0] rev3(input logic [2:0] v);
    rev3 = {v[0], v[1], v[2]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic        rst_meta_b;
  logic        rst_b;
  logic [15:0] oc1_meta;
  logic [15:0] oc1;
  logic [15:0] oc2_meta;
  logic [15:0] oc2;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_b <= 1'b0;
      rst_b      <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_b      <= rst_meta_b;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      oc1_meta <= 16'h0000;
      oc1      <= 16'h0000;
      oc2_meta <= 16'h0000;
      oc2      <= 16'h0000;
    end else begin
      oc1_meta <= i_first_output_channel;
      oc1      <= oc1_meta;
      oc2_meta <= i_second_output_channel;
      oc2      <= oc2_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // connect, select and set/clear pulse detection

  logic connected;
  logic selected;
  logic iclr_armed;
  logic pclr_armed;
  logic iclr_do;
  logic pclr_do;

  // connected only while the code is held, no latching
  assign connected = (oc1[`CPL_CONN_MSB:`CPL_CONN_LSB]
                      == `CPL_CONN_CODE);
  assign selected  = connected && oc1[`CPL_SEL_BIT];

  // arm on the set level, act on the following clear; a held bit
  // therefore fires once, never every cycle
  assign iclr_do = iclr_armed && !oc2[`CPL_ICLR_BIT];
  assign pclr_do = pclr_armed && !oc2[`CPL_PCLR_BIT];

  // the set is taken only while selected; a later deselect keeps it
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      iclr_armed <= 1'b0;
      pclr_armed <= 1'b0;
    end else begin
      if (!oc2[`CPL_ICLR_BIT]) begin
        iclr_armed <= 1'b0;
      end else if (selected) begin
        iclr_armed <= 1'b1;
      end
      if (!oc2[`CPL_PCLR_BIT]) begin
        pclr_armed <= 1'b0;
      end else if (selected) begin
        pclr_armed <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operation state machine

  cpl_state_t state;
  cpl_state_t next_state;
  logic       err;
  logic [2:0] err_cnt;
  logic       func_take;
  logic       func_end;
  logic       fifo_wr_ready;
  logic       fifo_clr;
  logic       rd_ok;
  logic       push;
  logic       fetch_go;
  logic       fetch_open;

  // an error locks out new work; only the end code gets through
  assign func_end  = i_b_func_stb && (i_b_func.code == `CPL_FC_END);
  assign func_take = i_b_func_stb && !err && !func_end;
  assign fifo_clr  = pclr_do || func_end;
  assign push      = (state == CPL_ST_WAIT) && i_mem_rd_valid;
  assign rd_ok     = word_ok(i_mem_rd);
  assign fetch_go  = (state == CPL_ST_READ) && (next_state == CPL_ST_WAIT);

  always_comb begin
    next_state = state;
    case (state)
      CPL_ST_IDLE: begin
        if (func_take && i_b_func.code == `CPL_FC_READ) begin
          next_state = CPL_ST_READ;
        end else if (func_take && i_b_func.code == `CPL_FC_WRITE) begin
          next_state = CPL_ST_WRITE;
        end
      end
      CPL_ST_READ: begin
        // one fetch in flight, only with room for its word and once
        // any fetch cut off earlier has answered
        if (fifo_wr_ready && !fetch_open) begin
          next_state = CPL_ST_WAIT;
        end
      end
      CPL_ST_WAIT: begin
        // a bad word does not end the read
        if (i_mem_rd_valid) begin
          next_state = CPL_ST_READ;
        end
      end
      CPL_ST_WRITE: begin
        next_state = CPL_ST_WRITE;
      end
      default: begin
        next_state = CPL_ST_IDLE;
      end
    endcase
    // only the far end's end code or a program clear stops an operation
    if (func_end || pclr_do) begin
      next_state = CPL_ST_IDLE;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= CPL_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // an end or clear does not recall a fetch already sent; its stale
  // answer is dropped outside the wait state and must come back first
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fetch_open <= 1'b0;
    end else if (fetch_go) begin
      fetch_open <= 1'b1;
    end else if (i_mem_rd_valid) begin
      fetch_open <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // memory port

  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      o_mem_rd_req  <= 1'b0;
      o_mem_wr_en   <= 1'b0;
      o_mem_addr    <= 16'h0000;
      o_mem_wr_data <= 16'h0000;
    end else begin
      o_mem_rd_req <= fetch_go;
      // a write word that meets an end or clear is dropped
      o_mem_wr_en  <= (state == CPL_ST_WRITE) && i_b_wr_valid
                      && !func_end && !pclr_do;
      if (func_take) begin
        o_mem_addr <= i_b_func.addr;
      end else if (push || o_mem_wr_en) begin
        // address advances once the word at it is done
        o_mem_addr <= `CPL_ADDR_W'(o_mem_addr + 1'b1);
      end
      if (i_b_wr_valid) begin
        o_mem_wr_data <= i_b_wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parity error status and bank count

  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      err         <= 1'b0;
      err_cnt     <= 3'h0;
      o_b_par_err <= 1'b0;
    end else begin
      o_b_par_err <= push && !rd_ok;
      if (push && !rd_ok && (!err || pclr_do || func_end)) begin
        // first failing word wins; later ones keep the first bank, but
        // a new error beats a clear in the same cycle
        err     <= 1'b1;
        err_cnt <= bank_cnt(o_mem_addr[`CPL_BANK_MSB:`CPL_BANK_LSB]);
      end else if (pclr_do || func_end) begin
        err     <= 1'b0;
        err_cnt <= 3'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // far end replies and interrupt flag

  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      o_b_func_refused <= 1'b0;
    end else begin
      o_b_func_refused <= i_b_func_stb && err && !func_end;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      o_int_from_b <= 1'b0;
    end else if (i_b_int_stb) begin
      // a new interrupt beats a clear in the same cycle
      o_int_from_b <= 1'b1;
    end else if (iclr_do) begin
      o_int_from_b <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fifth input channel

  logic [2:0] shown_cnt;

  // counter bits are shared: show whichever interface is selected
  assign shown_cnt = selected ? err_cnt : i_periph_bank_cnt;

  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      o_fifth_input_channel <= 16'h0000;
    end else begin
      // bits of the other interfaces read as zero here
      o_fifth_input_channel <= 16'h0000;
      o_fifth_input_channel[`CPL_ST_ERR_BIT] <= err;
      o_fifth_input_channel[`CPL_ST_BANK_MSB:`CPL_ST_BANK_LSB]
        <= rev3(shown_cnt);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read-data buffer toward the far end

  // head register holds one word beyond the array depth
  cpl_fifo #(
    .WIDTH (`CPL_WORD_W),
    .DEPTH (`CPL_FIFO_DEPTH),
    .AW    (`CPL_FIFO_AW)
  ) u_fifo (
    .i_clk      (i_clk_sys),
    .i_rst_b    (rst_b),
    .i_clr      (fifo_clr),
    .i_wr_valid (push),
    .i_wr_data  (i_mem_rd.data),
    .o_wr_ready (fifo_wr_ready),
    .o_rd_valid (o_b_rd_valid),
    .o_rd_data  (o_b_rd_data),
    .i_rd_ready (i_b_rd_ready)
  );

endmodule

// [cpl_mem_model.sv]
// buffer memory model: one fetch at a time, chosen latency, one bad word
module cpl_mem_model
  import cpl_pkg::*;
#(
  parameter logic [15:0] BAD_ADDR = 16'hA003
) (
  // clock and latency choice
  input  wire logic        i_clk,
  input  wire logic [1:0]  i_lat,
  // fetch request
  input  wire logic        i_rd_req,
  input  wire logic [15:0] i_addr,
  // answer
  output cpl_mem_word_t    o_rd,
  output logic             o_rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] addr_q;
  logic [15:0] d;
  logic [1:0]  wait_q;
  logic        busy = 1'b0;
  assign d = addr_q ^ 16'h5A3C;
  initial begin
    o_rd = '0;
    o_rd_valid = 1'b0;
  end
  always @(posedge i_clk) begin
    o_rd_valid <= 1'b0;
    // idle bits keep moving so a stale word never passes for an answer
    o_rd <= ~o_rd;
    if (i_rd_req) begin
      busy <= 1'b1;
      addr_q <= i_addr;
      wait_q <= i_lat;
    end else if (busy && wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (busy) begin
      busy <= 1'b0;
      o_rd_valid <= 1'b1;
      o_rd <= {d, ~^d[15:8], ~^d[7:0] ^ (addr_q == BAD_ADDR)};
    end
  end
endmodule

// [cpl_checker.sv]
// concurrent checks on the memory-side coupler ports
`include "cpl_cfg.svh"
module cpl_checker
  import cpl_pkg::*;
(
  // clock and reset
  input wire logic          i_clk_sys,
  input wire logic          i_rst_b,
  // processor channels
  input wire logic [15:0]   i_first_output_channel,
  input wire logic [15:0]   i_second_output_channel,
  input wire logic [15:0]   o_fifth_input_channel,
  input wire logic [2:0]    i_periph_bank_cnt,
  // memory and far end
  input wire logic          o_mem_rd_req,
  input wire logic          i_mem_rd_valid,
  input wire cpl_mem_word_t i_mem_rd,
  input wire logic          i_b_func_stb,
  input wire cpl_func_t     i_b_func,
  input wire logic          o_b_func_refused,
  input wire logic          i_b_rd_ready,
  input wire logic          o_b_par_err,
  input wire logic          o_int_from_b
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] hit;
  logic [2:0] age [5];
  wire        sel_pin = i_first_output_channel[`CPL_CONN_MSB:`CPL_CONN_LSB]
              == `CPL_CONN_CODE && i_first_output_channel[`CPL_SEL_BIT];
  wire        bad_word = i_mem_rd_valid &&
              !(^{i_mem_rd.data[7:0], i_mem_rd.par[0]} &&
                ^{i_mem_rd.data[15:8], i_mem_rd.par[1]});
  assign hit = {i_b_func_stb && i_b_func.code == `CPL_FC_END,
                i_second_output_channel[`CPL_PCLR_BIT],
                i_second_output_channel[`CPL_ICLR_BIT], sel_pin, !sel_pin};
  // cycles since each event, saturating so long runs stay cheap
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b)
      age <= '{default: 3'h0};
    else
      for (int i = 0; i < 5; i++)
        age[i] <= hit[i] ? 3'h0 : age[i] + {2'h0, age[i] != 3'h7};
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_read_while_err;
    i_b_func_stb && i_b_func.code == `CPL_FC_READ ##1 o_fifth_input_channel[0];
  endsequence
  a_par_err_cause: assert property (o_b_par_err |-> $past(bad_word))
    else $error("parity error flagged on a good word");
  a_par_err_report: assert property (bad_word |=> o_b_par_err)
    else $error("bad word not reported to far end");
  a_read_goes_on: assert property (o_b_par_err && i_b_rd_ready &&
    !i_b_func_stb |-> ##[1:4] o_mem_rd_req)
    else $error("block read halted by parity error");
  a_refuse_lock: assert property (s_read_while_err |-> o_b_func_refused)
    else $error("new operation taken while error locked");
  a_refuse_cause: assert property (o_b_func_refused |->
    $past(i_b_func_stb) && $past(i_b_func.code) != `CPL_FC_END)
    else $error("refusal without a refused code");
  a_bank_hold: assert property (o_fifth_input_channel[0] &&
    $past(o_fifth_input_channel[0]) && age[0] == 3'h7
    |-> $stable(o_fifth_input_channel[3:1]))
    else $error("bank bits moved while error held");
  a_err_cleared: assert property ($fell(o_fifth_input_channel[0]) |->
    age[3] inside {[1:6]} || age[4] inside {[1:3]})
    else $error("error bit dropped without end or clear");
  a_unsel_bank: assert property (age[1] == 3'h7 |->
    {o_fifth_input_channel[1], o_fifth_input_channel[2],
     o_fifth_input_channel[3]} == $past(i_periph_bank_cnt))
    else $error("unselected bank bits not shared counter");
  a_int_clear: assert property ($fell(o_int_from_b) |->
    age[2] inside {[1:5]})
    else $error("interrupt flag dropped without clear pulse");
endmodule

// [tb_top.sv]
// self-checking bench for the memory-side coupler
`include "cpl_cfg.svh"
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, a); end end
module tb_top
  import cpl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { logic [15:0] a; logic [15:0] d; } cpl_row_t;
  logic          clk, rst_b, rd_req, wr_en, mvalid, fstb, refused;
  logic          bwv, brv, brr, perr, istb, intb;
  logic [1:0]    lat;
  logic [2:0]    pcnt;
  logic [15:0]   foc, soc, fic, maddr, wdata, bwd, brd;
  logic [15:0]   got[$];
  logic [15:0]   ints[3] = '{16'h0100, 16'h6000, 16'h6100};
  cpl_mem_word_t mrd;
  cpl_func_t     func;
  int            err_count, n_tests, n_perr, n_req;
  cpl_row_t      rows[6] = '{'{16'hA000, 16'hFA3C}, '{16'hA001, 16'hFA3D},
    '{16'hA002, 16'hFA3E}, '{16'hA003, 16'hFA3F}, '{16'hA004, 16'hFA38},
    '{16'hA005, 16'hFA39}};
  cpl_coupler dut (.i_clk_sys(clk), .i_rst_b(rst_b),
    .i_first_output_channel(foc), .i_second_output_channel(soc),
    .o_fifth_input_channel(fic), .i_periph_bank_cnt(pcnt),
    .o_mem_rd_req(rd_req), .o_mem_wr_en(wr_en), .o_mem_addr(maddr),
    .o_mem_wr_data(wdata), .i_mem_rd_valid(mvalid), .i_mem_rd(mrd),
    .i_b_func_stb(fstb), .i_b_func(func), .o_b_func_refused(refused),
    .i_b_wr_valid(bwv), .i_b_wr_data(bwd), .o_b_rd_valid(brv),
    .o_b_rd_data(brd), .i_b_rd_ready(brr), .o_b_par_err(perr),
    .i_b_int_stb(istb), .o_int_from_b(intb));
  cpl_mem_model mem (.i_clk(clk), .i_lat(lat), .i_rd_req(rd_req),
    .i_addr(maddr), .o_rd(mrd), .o_rd_valid(mvalid));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (brv && brr) got.push_back(brd);
    n_perr += perr;
    n_req += rd_req;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic fn(input logic [1:0] c, input logic [15:0] a);
    @(negedge clk);
    fstb = 1'b1;
    func.code = c;
    func.addr = a;
    @(negedge clk);
    fstb = 1'b0;
  endtask
  // set, hold, clear: pins pass two flops, so each level must stand a while
  task automatic ctl(input int b);
    soc[b] = 1'b1;
    cyc(4);
    soc[b] = 1'b0;
    cyc(6);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // whole run is about 360 cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int r;
    rst_b = 1'b0;
    foc = 16'h0000;
    soc = 16'h0000;
    pcnt = 3'h6;
    lat = 2'h0;
    fstb = 1'b0;
    func = '0;
    bwv = 1'b0;
    bwd = 16'h0000;
    brr = 1'b0;
    istb = 1'b0;
    cyc(8);
    rst_b = 1'b1;
    cyc(6);
    `CHK("status error", 1'b0, fic[0])
    `CHK("shared bank", 3'h6, {fic[1], fic[2], fic[3]})
    $display("test reset done");
    foc = 16'h6100;
    cyc(4);
    fn(`CPL_FC_READ, 16'hA000);
    cyc(150);
    r = n_req;
    cyc(20);
    `CHK("fetch while full", r, n_req)
    `CHK("words while stalled", 0, got.size())
    brr = 1'b1;
    cyc(20);
    foreach (rows[i]) `CHK("read word", rows[i].d, got[i])
    `CHK("error pulses", 1, n_perr)
    `CHK("error bit", 1'b1, fic[0])
    `CHK("bank count", ~(3'h5 + 3'h4), {fic[1], fic[2], fic[3]})
    for (int c = 1; c < 3; c++) begin
      fn(2'(c), 16'h0000);
      `CHK("refused", 1'b1, refused)
    end
    fn(`CPL_FC_END, 16'h0000);
    cyc(3);
    `CHK("end clears", 1'b0, fic[0])
    $display("test block read done");
    lat = 2'h3;
    fn(`CPL_FC_READ, 16'hA000);
    cyc(60);
    `CHK("slow error", 1'b1, fic[0])
    ctl(`CPL_PCLR_BIT);
    `CHK("clear status", 4'h0, fic[3:0])
    r = n_req;
    cyc(10);
    `CHK("read stopped", r, n_req)
    fn(`CPL_FC_READ, 16'h0100);
    `CHK("lock released", 1'b0, refused)
    fn(`CPL_FC_END, 16'h0000);
    $display("test program clear done");
    fn(`CPL_FC_WRITE, 16'h0200);
    bwv = 1'b1;
    bwd = 16'h1234;
    cyc(1);
    bwv = 1'b0;
    `CHK("write enable", 1'b1, wr_en)
    `CHK("write address", 16'h0200, maddr)
    `CHK("write data", 16'h1234, wdata)
    cyc(1);
    `CHK("write done", 1'b0, wr_en)
    `CHK("address step", 16'h0201, maddr)
    fn(`CPL_FC_END, 16'h0000);
    $display("test write done");
    istb = 1'b1;
    cyc(1);
    istb = 1'b0;
    cyc(2);
    `CHK("interrupt set", 1'b1, intb)
    foreach (ints[i]) begin
      foc = ints[i];
      cyc(4);
      ctl(`CPL_ICLR_BIT);
      `CHK("interrupt flag", i < 2, intb)
    end
    $display("test interrupt clear done");
    print_verdict();
  end
endmodule
bind cpl_coupler cpl_checker chk (.i_clk_sys, .i_rst_b,
  .i_first_output_channel, .i_second_output_channel,
  .o_fifth_input_channel, .i_periph_bank_cnt, .o_mem_rd_req,
  .i_mem_rd_valid, .i_mem_rd, .i_b_func_stb, .i_b_func,
  .o_b_func_refused, .i_b_rd_ready, .o_b_par_err, .o_int_from_b);
